// file: rtl/ppsb_pkg.sv
// Package for the port power status bank: offsets, bit positions, types.
// Assumes an 8-bit register port decoded by the serial bus engine upstream.
package ppsb_pkg;

    // Register offsets on the register port.
    localparam logic [7:0] PPSB_OFS_PIN_EMU = 8'h0F;
    localparam logic [7:0] PPSB_OFS_FAULT = 8'h10;
    localparam logic [7:0] PPSB_OFS_EVENT = 8'h11;
    localparam logic [7:0] PPSB_OFS_PROFILE = 8'h12;
    localparam logic [7:0] PPSB_UNMAPPED_DATA = 8'h00;

    // Field positions in fault_status.
    localparam int PPSB_ERR_BIT = 7;
    localparam int PPSB_RST_BIT = 5;

    // Live fault vector order: discharge, keep-out, thermal shutdown,
    // source overvoltage, reverse voltage, overcurrent.
    localparam int PPSB_NFAULT = 6;
    localparam logic [PPSB_NFAULT-1:0] PPSB_NO_FAULT = 6'h00;

    // Idle step code and reset flag value.
    localparam logic [1:0] PPSB_STEP_NONE = 2'h0;
    localparam logic PPSB_RST_FLAG_INIT = 1'b1;

    // Budget response code that selects a host interrupt.
    localparam logic [1:0] PPSB_BUDGET_RESP_IRQ = 2'h0;

    // Back-voltage margin, applied by the analog comparator.
    localparam int PPSB_REVERSE_VOLTAGE_FLAG_MV = 150;

    // Error handling states.
    typedef enum logic [0:0] {
        PPSB_ST_ACTIVE = 1'b0,
        PPSB_ST_ERROR = 1'b1
    } ppsb_state_t;

    // One register port access, valid for one cycle.
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ppsb_req_t;

    // Accepted profile indication bundle.
    typedef struct packed {
        logic handshake_absent;
        logic user_profile_accepted;
        logic dcp;
        logic cdp;
        logic passthrough_flag;
    } ppsb_profile_t;

endpackage

// file: rtl/ppsb_status_bank.sv
// Port power status bank: status registers, fault/error handling, pin drive.
// Assumes analog comparators and pins arrive asynchronously and emulation
// engine events arrive as one-cycle pulses on this clock.
`timescale 1ns/1ps

module ppsb_status_bank
    import ppsb_pkg::*;
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Register port.
    input wire ppsb_req_t req_i,
    output logic [7:0] rdata_o,
    // Asynchronous comparator levels.
    input wire logic ibus_over_chg_i,
    input wire logic ibus_overcurrent_flag_i,
    input wire logic ibus_over_r2min_i,
    input wire logic vbus_over_supply_i,
    input wire logic discharge_fail_i,
    input wire logic vbus_keepout_i,
    input wire logic thermal_shutdown_i,
    input wire logic source_overvoltage_i,
    input wire logic thermal_reg_i,
    input wire logic low_current_i,
    input wire logic source_uvlo_i,
    input wire logic power_enable_control_i,
    input wire logic first_mode_select_i,
    // Open-drain pin readback.
    input wire logic alert_pin_i,
    input wire logic plug_detect_pin_i,
    // Same-clock controls and events.
    input wire logic auto_recovery_i,
    input wire logic alert_mask_i,
    input wire logic alert_link_i,
    input wire logic budget_enable_i,
    input wire logic budget_clear_i,
    input wire logic [1:0] budget_response_select_i,
    input wire logic budget_reached_i,
    input wire logic attach_event_i,
    input wire logic removal_event_i,
    input wire logic emulation_running_i,
    input wire logic [1:0] stimulus_step_i,
    input wire logic dce_cycle_i,
    input wire logic profile_applied_i,
    input wire logic profile_end_nohs_i,
    input wire logic new_mode_i,
    input wire logic passthrough_mode_i,
    input wire logic user_accept_i,
    input wire logic dcp_accept_i,
    input wire logic cdp_accept_i,
    input wire logic dedicated_switch_setting_i,
    input wire logic custom_switch_setting_i,
    input wire logic custom_constant_limit_i,
    // Pins and control outputs.
    output logic alert_o,
    output logic alert_oe_n_o,
    output logic plug_detect_output_o,
    output logic plug_detect_oe_n_o,
    output logic error_state_o,
    output logic power_switch_off_o,
    output logic data_switch_closed_o,
    output logic constant_limit_o
);

    localparam int NSYNC = 15;

    logic [NSYNC-1:0] sync1_reg;
    logic [NSYNC-1:0] sync2_reg;
    logic [NSYNC-1:0] async_in;
    logic chg_s, ilim_s, r2_s, bv_s, dis_s, keep_s, tsd_s, ov_s;
    logic thermal_throttle_flag_s, low_s, uvlo_s, pe_s, m1_s, alert_low_s, plug_low_s;
    logic [PPSB_NFAULT-1:0] live_flt;
    logic [PPSB_NFAULT-1:0] flt_reg;
    logic err_reg, rst_flag_reg, pe_q_reg, m1_q_reg;
    logic budget_reg, thermal_throttle_flag_reg, low_reg, rem_reg, att_reg;
    logic plug_reg, pt_arm_reg;
    ppsb_profile_t prof_reg;
    ppsb_state_t state_reg;
    logic rd_fault, rd_event, wr_err_clr, err_clr, err_set, pe_toggle;
    logic prof_clr, alert_next;

    assign async_in = {ibus_over_chg_i, ibus_overcurrent_flag_i, ibus_over_r2min_i,
        vbus_over_supply_i, discharge_fail_i, vbus_keepout_i,
        thermal_shutdown_i, source_overvoltage_i, thermal_reg_i,
        low_current_i, source_uvlo_i, power_enable_control_i,
        first_mode_select_i, ~alert_pin_i, ~plug_detect_pin_i};

    // Every external level passes two flops before use.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= async_in;
            sync2_reg <= sync1_reg;
        end
    end

    assign {chg_s, ilim_s, r2_s, bv_s, dis_s, keep_s, tsd_s, ov_s, thermal_throttle_flag_s,
        low_s, uvlo_s, pe_s, m1_s, alert_low_s, plug_low_s} = sync2_reg;

    // The comparator itself applies the 150 mV margin on reverse voltage.
    assign live_flt = {dis_s, keep_s, tsd_s, ov_s, bv_s,
        ilim_s & r2_s};

    assign rd_fault = req_i.rd && req_i.addr == PPSB_OFS_FAULT;
    assign rd_event = req_i.rd && req_i.addr == PPSB_OFS_EVENT;
    assign wr_err_clr = req_i.wr && req_i.addr == PPSB_OFS_FAULT &&
        !req_i.wdata[PPSB_ERR_BIT];
    assign pe_toggle = pe_s != pe_q_reg;
    assign err_clr = wr_err_clr || !pe_s ||
        (auto_recovery_i && live_flt == PPSB_NO_FAULT);
    // A fault still present re-raises the error bit, so a clear write loses.
    assign err_set = live_flt != PPSB_NO_FAULT;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pe_q_reg <= 1'b0;
            m1_q_reg <= 1'b0;
        end else begin
            pe_q_reg <= pe_s;
            m1_q_reg <= m1_s;
        end
    end

    // A live fault wins over a read or an error clear in the same cycle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flt_reg <= PPSB_NO_FAULT;
        end else begin
            flt_reg <= live_flt | (flt_reg & ~({PPSB_NFAULT{rd_fault}} &
                ~live_flt) & ~{PPSB_NFAULT{err_clr && !err_set}});
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            err_reg <= 1'b0;
        end else if (err_set) begin
            err_reg <= 1'b1;
        end else if (err_clr) begin
            err_reg <= 1'b0;
        end
    end

    // Error is left only once the error, reset and every fault bit are clear.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= PPSB_ST_ACTIVE;
        end else begin
            unique case (state_reg)
                PPSB_ST_ACTIVE: begin
                    if (err_set) begin
                        state_reg <= PPSB_ST_ERROR;
                    end
                end
                PPSB_ST_ERROR: begin
                    if (!(err_reg || rst_flag_reg || |flt_reg)) begin
                        state_reg <= PPSB_ST_ACTIVE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rst_flag_reg <= PPSB_RST_FLAG_INIT;
        end else if (rd_fault || pe_toggle) begin
            rst_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            budget_reg <= 1'b0;
        end else if (budget_reached_i) begin
            budget_reg <= 1'b1;
        end else if (rd_event || budget_clear_i || !budget_enable_i) begin
            budget_reg <= 1'b0;
        end
    end

    // Event flags: the set wins over a read in the same cycle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            thermal_throttle_flag_reg <= 1'b0;
            low_reg <= 1'b0;
            rem_reg <= 1'b0;
            att_reg <= 1'b0;
        end else begin
            thermal_throttle_flag_reg <= thermal_throttle_flag_s || (thermal_throttle_flag_reg && !rd_event);
            low_reg <= low_s || (low_reg && !rd_event);
            rem_reg <= removal_event_i || (rem_reg && !rd_event);
            att_reg <= attach_event_i || (att_reg && !rd_event);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            plug_reg <= 1'b0;
        end else if (attach_event_i) begin
            plug_reg <= 1'b1;
        end else if (removal_event_i) begin
            plug_reg <= 1'b0;
        end
    end

    // Pass-through stays disarmed after removal until the mode changes.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pt_arm_reg <= 1'b1;
        end else if (new_mode_i || m1_s != m1_q_reg) begin
            pt_arm_reg <= 1'b1;
        end else if (removal_event_i) begin
            pt_arm_reg <= 1'b0;
        end
    end

    assign prof_clr = !pe_s || new_mode_i || removal_event_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prof_reg <= '0;
        end else begin
            if (user_accept_i) begin
                prof_reg.user_profile_accepted <= 1'b1;
            end else if (prof_clr) begin
                prof_reg.user_profile_accepted <= 1'b0;
            end
            if (dcp_accept_i) begin
                prof_reg.dcp <= 1'b1;
            end else if (prof_clr) begin
                prof_reg.dcp <= 1'b0;
            end
            if (cdp_accept_i) begin
                prof_reg.cdp <= 1'b1;
            end else if (prof_clr) begin
                prof_reg.cdp <= 1'b0;
            end
            if (passthrough_mode_i && pt_arm_reg && !prof_clr) begin
                prof_reg.passthrough_flag <= 1'b1;
            end else if (prof_clr) begin
                prof_reg.passthrough_flag <= 1'b0;
            end
        end
    end

    // Any accepted profile outranks the no-handshake indication.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prof_reg.handshake_absent <= 1'b0;
        end else if (user_accept_i || dcp_accept_i || cdp_accept_i ||
                prof_reg.user_profile_accepted || prof_reg.dcp ||
                prof_reg.cdp || prof_reg.passthrough_flag) begin
            prof_reg.handshake_absent <= 1'b0;
        end else if (dce_cycle_i && profile_end_nohs_i) begin
            prof_reg.handshake_absent <= 1'b1;
        end else if (profile_applied_i) begin
            prof_reg.handshake_absent <= 1'b0;
        end
    end

    // Reset, unplug, plug-in and profile bits never feed the alert.
    assign alert_next = !alert_mask_i && (flt_reg != PPSB_NO_FAULT ||
        (budget_reg &&
         budget_response_select_i == PPSB_BUDGET_RESP_IRQ) ||
        (alert_link_i && (thermal_throttle_flag_reg || low_reg)));

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            alert_oe_n_o <= 1'b1;
            plug_detect_oe_n_o <= 1'b1;
        end else begin
            alert_oe_n_o <= !alert_next;
            plug_detect_oe_n_o <= !plug_reg;
        end
    end

    assign alert_o = 1'b0;
    assign plug_detect_output_o = 1'b0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            error_state_o <= 1'b0;
            power_switch_off_o <= 1'b1;
            data_switch_closed_o <= 1'b0;
            constant_limit_o <= 1'b0;
        end else begin
            error_state_o <= state_reg == PPSB_ST_ERROR;
            power_switch_off_o <= uvlo_s ||
                state_reg == PPSB_ST_ERROR;
            if (prof_reg.user_profile_accepted) begin
                data_switch_closed_o <= custom_switch_setting_i;
                constant_limit_o <= custom_constant_limit_i;
            end else if (prof_reg.dcp) begin
                data_switch_closed_o <= dedicated_switch_setting_i;
                constant_limit_o <= 1'b1;
            end else begin
                data_switch_closed_o <= prof_reg.cdp ||
                    prof_reg.passthrough_flag;
                constant_limit_o <= 1'b0;
            end
        end
    end

    // Reads return the value before any clear-on-read takes effect.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_o <= PPSB_UNMAPPED_DATA;
        end else if (req_i.rd) begin
            unique case (req_i.addr)
                PPSB_OFS_PIN_EMU: rdata_o <= {2'b00, alert_low_s,
                    plug_low_s, chg_s, emulation_running_i,
                    emulation_running_i ? stimulus_step_i :
                    PPSB_STEP_NONE};
                PPSB_OFS_FAULT: rdata_o <= {err_reg, flt_reg[5],
                    rst_flag_reg, flt_reg[4:0]};
                PPSB_OFS_EVENT: rdata_o <= {budget_reg, 2'b00, ilim_s,
                    thermal_throttle_flag_reg, low_reg, rem_reg, att_reg};
                PPSB_OFS_PROFILE: rdata_o <= {prof_reg.handshake_absent,
                    2'b00, uvlo_s, prof_reg.user_profile_accepted,
                    prof_reg.dcp, prof_reg.cdp,
                    prof_reg.passthrough_flag};
                default: rdata_o <= PPSB_UNMAPPED_DATA;
            endcase
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_fault_sets_err: assert property (
        state_reg == PPSB_ST_ACTIVE && live_flt != PPSB_NO_FAULT |=>
        err_reg && state_reg == PPSB_ST_ERROR)
        else $error("fault did not enter error");
    chk_err_held_faults: assert property (
        state_reg == PPSB_ST_ERROR && flt_reg != PPSB_NO_FAULT |=>
        state_reg == PPSB_ST_ERROR)
        else $error("left error with fault bits set");
    chk_pe_clears_err: assert property (
        !pe_s && !err_set |=> !err_reg)
        else $error("error bit kept with power disabled");
    chk_fault_alert_pin: assert property (
        flt_reg != PPSB_NO_FAULT && !alert_mask_i |=> !alert_oe_n_o)
        else $error("fault without alert");
    chk_reset_flag_read: assert property (
        rd_fault |=> !rst_flag_reg)
        else $error("reset flag survived read");
    chk_budget_clear: assert property (
        !budget_reached_i && (budget_clear_i || !budget_enable_i) |=>
        !budget_reg)
        else $error("budget flag not cleared");
    chk_attach_pin: assert property (
        attach_event_i |=> plug_reg ##1 !plug_detect_oe_n_o)
        else $error("attach did not assert plug output");
    chk_removal_pin: assert property (
        removal_event_i && !attach_event_i |-> ##2
        plug_detect_oe_n_o)
        else $error("removal did not release plug output");
    chk_nohs_exclusive: assert property (
        prof_reg.handshake_absent |-> !(prof_reg.user_profile_accepted ||
        prof_reg.dcp || prof_reg.cdp || prof_reg.passthrough_flag))
        else $error("no-handshake set with a profile");
    chk_uvlo_switch_off: assert property (
        uvlo_s |=> power_switch_off_o)
        else $error("switch on during source undervoltage");
    chk_prof_clear: assert property (
        removal_event_i && !user_accept_i && !dcp_accept_i &&
        !cdp_accept_i |=> !prof_reg.dcp && !prof_reg.cdp &&
        !prof_reg.passthrough_flag)
        else $error("profile bits survived removal");

    cov_error_recover: cover property (
        state_reg == PPSB_ST_ERROR ##[1:50] state_reg == PPSB_ST_ACTIVE);
    cov_attach_remove: cover property (
        attach_event_i ##[1:50] removal_event_i);
    cov_budget_alert: cover property (budget_reg && !alert_oe_n_o);
    cov_nohs_seen: cover property (prof_reg.handshake_absent);

endmodule

// file: tb/ppsb_host_model.sv
// Host model: issues single-byte reads and writes on the register port.
// Assumes one access at a time and read data that stands until next read.
`timescale 1ns/1ps

module ppsb_host_model
    import ppsb_pkg::*;
(
    // Clock.
    input wire logic clk_i,
    // Register port.
    output ppsb_req_t req_o,
    input wire logic [7:0] rdata_i
);
    initial begin
        req_o = '0;
    end

    // Data is taken one edge late; it stands until the next read anyway.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        req_o <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(posedge clk_i);
        req_o <= '0;
        @(posedge clk_i);
        #1 d = rdata_i;
    endtask

    // A zero in the error bit asks the device to recheck its faults.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        req_o <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge clk_i);
        req_o <= '0;
        repeat (2) @(posedge clk_i);
        #1;
    endtask
endmodule

// file: tb/ppsb_status_bank_tb_top.sv
// Testbench for the port power status bank, one task per scenario.
// Assumes pulled-up open-drain pins and a single 125 MHz clock.
`timescale 1ns/1ps

module ppsb_status_bank_tb_top;
    import ppsb_pkg::*;

    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    ppsb_req_t req;
    logic [7:0] rdata;
    logic [12:0] lv = 13'h0000;
    logic [8:0] ev = 9'h000;
    logic [14:0] cf = 15'h0000;
    logic al_o, al_n, pd_o, pd_n, err, psw, dsw, cl;
    int failures = 0;
    int check_count = 0;
    // Both pins idle high through their pull-ups when released.
    wire al_w = al_n ? 1'b1 : al_o;
    wire pd_w = pd_n ? 1'b1 : pd_o;

    always #4 clk_i = ~clk_i;

    ppsb_host_model i_ppsb_host_model (.clk_i(clk_i), .req_o(req),
        .rdata_i(rdata));

    ppsb_status_bank i_ppsb_status_bank (.clk_i(clk_i), .rst_i(rst_i),
        .req_i(req), .rdata_o(rdata), .ibus_over_chg_i(lv[0]),
        .ibus_overcurrent_flag_i(lv[1]), .ibus_over_r2min_i(lv[2]),
        .vbus_over_supply_i(lv[3]), .discharge_fail_i(lv[4]),
        .vbus_keepout_i(lv[5]), .thermal_shutdown_i(lv[6]),
        .source_overvoltage_i(lv[7]), .thermal_reg_i(lv[8]),
        .low_current_i(lv[9]), .source_uvlo_i(lv[10]),
        .power_enable_control_i(lv[11]), .first_mode_select_i(lv[12]),
        .alert_pin_i(al_w), .plug_detect_pin_i(pd_w),
        .auto_recovery_i(cf[0]), .alert_mask_i(cf[1]),
        .alert_link_i(cf[2]), .budget_enable_i(cf[3]),
        .budget_clear_i(cf[4]), .budget_response_select_i(cf[6:5]),
        .budget_reached_i(ev[0]), .attach_event_i(ev[1]),
        .removal_event_i(ev[2]), .emulation_running_i(cf[11]),
        .stimulus_step_i(cf[13:12]), .dce_cycle_i(cf[14]),
        .profile_applied_i(ev[3]), .profile_end_nohs_i(ev[4]),
        .new_mode_i(ev[5]), .passthrough_mode_i(cf[10]),
        .user_accept_i(ev[6]), .dcp_accept_i(ev[7]), .cdp_accept_i(ev[8]),
        .dedicated_switch_setting_i(cf[7]),
        .custom_switch_setting_i(cf[8]), .custom_constant_limit_i(cf[9]),
        .alert_o(al_o), .alert_oe_n_o(al_n), .plug_detect_output_o(pd_o),
        .plug_detect_oe_n_o(pd_n), .error_state_o(err),
        .power_switch_off_o(psw), .data_switch_closed_o(dsw),
        .constant_limit_o(cl));

    task automatic chk(input string n, input logic [7:0] e,
        input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        i_ppsb_host_model.rd(a, d);
        chk($sformatf("reg %h", a), e, d);
    endtask

    task automatic pulse(input int i);
        @(posedge clk_i);
        ev <= 9'h001 << i;
        @(posedge clk_i);
        ev <= 9'h000;
        repeat (3) @(posedge clk_i);
        #1;
    endtask

    // Asynchronous levels need two sync edges plus the flag edge.
    task automatic lvl(input int i, input logic v);
        @(posedge clk_i);
        lv[i] <= v;
        repeat (6) @(posedge clk_i);
        #1;
    endtask

    task automatic cfg(input int i, input logic v);
        @(posedge clk_i);
        cf[i] <= v;
        @(posedge clk_i);
        #1;
    endtask

    task automatic t_reset;
        rdc(PPSB_OFS_FAULT, 8'h20);
        rdc(PPSB_OFS_FAULT, 8'h00);
        chk("alert", 8'h01, 8'(al_n));
        rdc(8'h20, PPSB_UNMAPPED_DATA);
        lvl(11, 1'b1);
        $display("test reset done");
    endtask

    task automatic t_plug;
        pulse(1);
        chk("plug", 8'h00, 8'(pd_n));
        chk("alert", 8'h01, 8'(al_n));
        rdc(PPSB_OFS_EVENT, 8'h01);
        rdc(PPSB_OFS_PIN_EMU, 8'h10);
        rdc(PPSB_OFS_EVENT, 8'h00);
        pulse(2);
        chk("plug", 8'h01, 8'(pd_n));
        rdc(PPSB_OFS_EVENT, 8'h02);
        rdc(PPSB_OFS_PIN_EMU, 8'h00);
        chk("alert", 8'h01, 8'(al_n));
        $display("test plug done");
    endtask

    task automatic t_emu;
        lvl(0, 1'b1);
        cfg(11, 1'b1);
        for (int s = 0; s < 4; s++) begin
            @(posedge clk_i);
            cf[13:12] <= 2'(s);
            rdc(PPSB_OFS_PIN_EMU, 8'h0C | 8'(s));
        end
        cfg(11, 1'b0);
        rdc(PPSB_OFS_PIN_EMU, 8'h08);
        lvl(0, 1'b0);
        rdc(PPSB_OFS_PIN_EMU, 8'h00);
        $display("test emulation done");
    endtask

    task automatic t_fault;
        int idx[5] = '{4, 5, 6, 7, 3};
        logic [7:0] bv[5] = '{8'h40, 8'h10, 8'h08, 8'h04, 8'h02};
        for (int k = 0; k < 5; k++) begin
            lvl(idx[k], 1'b1);
            chk("error", 8'h01, 8'(err));
            chk("alert", 8'h00, 8'(al_n));
            rdc(PPSB_OFS_FAULT, 8'h80 | bv[k]);
            rdc(PPSB_OFS_PIN_EMU, 8'h20);
            i_ppsb_host_model.wr(PPSB_OFS_FAULT, 8'h00);
            rdc(PPSB_OFS_FAULT, 8'h80 | bv[k]);
            lvl(idx[k], 1'b0);
            rdc(PPSB_OFS_FAULT, 8'h80 | bv[k]);
            rdc(PPSB_OFS_FAULT, 8'h80);
            i_ppsb_host_model.wr(PPSB_OFS_FAULT, 8'h80);
            chk("error", 8'h01, 8'(err));
            i_ppsb_host_model.wr(PPSB_OFS_FAULT, 8'h00);
            chk("error", 8'h00, 8'(err));
            chk("alert", 8'h01, 8'(al_n));
            rdc(PPSB_OFS_FAULT, 8'h00);
        end
        lvl(1, 1'b1);
        rdc(PPSB_OFS_EVENT, 8'h10);
        chk("error", 8'h00, 8'(err));
        lvl(2, 1'b1);
        chk("error", 8'h01, 8'(err));
        rdc(PPSB_OFS_FAULT, 8'h81);
        cfg(0, 1'b1);
        lvl(1, 1'b0);
        lvl(2, 1'b0);
        chk("error", 8'h00, 8'(err));
        rdc(PPSB_OFS_FAULT, 8'h00);
        rdc(PPSB_OFS_EVENT, 8'h00);
        cfg(0, 1'b0);
        lvl(6, 1'b1);
        lvl(6, 1'b0);
        chk("error", 8'h01, 8'(err));
        lvl(11, 1'b0);
        chk("error", 8'h00, 8'(err));
        lvl(11, 1'b1);
        $display("test fault done");
    endtask

    task automatic t_link;
        lvl(8, 1'b1);
        lvl(8, 1'b0);
        chk("alert", 8'h01, 8'(al_n));
        rdc(PPSB_OFS_EVENT, 8'h08);
        rdc(PPSB_OFS_EVENT, 8'h00);
        cfg(2, 1'b1);
        lvl(9, 1'b1);
        lvl(9, 1'b0);
        chk("alert", 8'h00, 8'(al_n));
        rdc(PPSB_OFS_EVENT, 8'h04);
        chk("alert", 8'h01, 8'(al_n));
        cfg(1, 1'b1);
        lvl(9, 1'b1);
        lvl(9, 1'b0);
        chk("alert", 8'h01, 8'(al_n));
        cfg(1, 1'b0);
        chk("alert", 8'h00, 8'(al_n));
        rdc(PPSB_OFS_EVENT, 8'h04);
        chk("alert", 8'h01, 8'(al_n));
        cfg(2, 1'b0);
        $display("test link done");
    endtask

    task automatic t_budget;
        cfg(3, 1'b1);
        pulse(0);
        chk("alert", 8'h00, 8'(al_n));
        rdc(PPSB_OFS_EVENT, 8'h80);
        chk("alert", 8'h01, 8'(al_n));
        cfg(5, 1'b1);
        pulse(0);
        chk("alert", 8'h01, 8'(al_n));
        cfg(4, 1'b1);
        cfg(4, 1'b0);
        rdc(PPSB_OFS_EVENT, 8'h00);
        $display("test budget done");
    endtask

    task automatic t_prof;
        cfg(10, 1'b1);
        pulse(5);
        rdc(PPSB_OFS_PROFILE, 8'h01);
        chk("dsw", 8'h01, 8'(dsw));
        chk("cl", 8'h00, 8'(cl));
        chk("plug", 8'h01, 8'(pd_n));
        pulse(2);
        rdc(PPSB_OFS_PROFILE, 8'h00);
        pulse(1);
        rdc(PPSB_OFS_PROFILE, 8'h00);
        lvl(12, 1'b1);
        rdc(PPSB_OFS_PROFILE, 8'h01);
        cfg(10, 1'b0);
        pulse(5);
        rdc(PPSB_OFS_PROFILE, 8'h00);
        pulse(7);
        rdc(PPSB_OFS_PROFILE, 8'h04);
        chk("cl", 8'h01, 8'(cl));
        chk("dsw", 8'h00, 8'(dsw));
        pulse(5);
        pulse(8);
        rdc(PPSB_OFS_PROFILE, 8'h02);
        chk("dsw", 8'h01, 8'(dsw));
        chk("cl", 8'h00, 8'(cl));
        pulse(5);
        cfg(8, 1'b1);
        cfg(9, 1'b1);
        pulse(6);
        rdc(PPSB_OFS_PROFILE, 8'h08);
        chk("dsw", 8'h01, 8'(dsw));
        chk("cl", 8'h01, 8'(cl));
        pulse(5);
        cfg(14, 1'b1);
        pulse(3);
        pulse(4);
        rdc(PPSB_OFS_PROFILE, 8'h80);
        pulse(3);
        rdc(PPSB_OFS_PROFILE, 8'h00);
        chk("plug", 8'h00, 8'(pd_n));
        lvl(10, 1'b1);
        rdc(PPSB_OFS_PROFILE, 8'h10);
        chk("psw", 8'h01, 8'(psw));
        lvl(10, 1'b0);
        chk("psw", 8'h00, 8'(psw));
        $display("test profile done");
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        t_reset();
        t_plug();
        t_emu();
        t_fault();
        t_link();
        t_budget();
        t_prof();
        print_verdict();
    end

    // The whole run needs about 600 cycles; the 25000-cycle limit is ample margin.
    initial begin
        #200000;
        failures++;
        print_verdict();
    end
endmodule
